// *** design/clock_supply_control.sv ***
`timescale 1ns/10ps
module clock_supply_control (
    // APB slave
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Oscillators and PLL
    output logic                              fast_osc_enable,
    output logic      [2:0]                   vco_multiplier,
    output logic                              slow_osc_enable,
    input  wire logic                         slow_osc_clock,
    // Derived clocks
    output clock_supply_pkg::clock_gate_t     clock_gates,
    output logic                              slow_clock,
    output logic                              processor_clock_out_pin,
    // Supply selection
    input  wire logic                         bus_supply_present,
    input  wire logic                         battery_supply_present,
    output clock_supply_pkg::supply_switch_t  supply_switches
);

    // ************************************************************
    // Register file
    // ************************************************************
    clock_supply_pkg::master_ctl_t master_ctl;
    clock_supply_pkg::master_ctl_t next_master_ctl;
    logic [clock_supply_pkg::DIV_W-1:0] cpu_div;
    logic [clock_supply_pkg::DIV_W-1:0] next_cpu_div;
    logic [31:0]                        next_prdata;
    logic                               hit_master;
    logic                               hit_cpu;
    logic                               hit_status;
    logic                               mapped;
    logic                               wr_master;
    logic                               wr_cpu;
    clock_supply_pkg::status_t          status;

    // Address decode
    always_comb begin
        hit_master = 1'b0;
        hit_cpu    = 1'b0;
        hit_status = 1'b0;
        if (paddr == clock_supply_pkg::MASTER_CTL_ADDR) begin
            hit_master = 1'b1;
        end else if (paddr == clock_supply_pkg::CPU_DIV_ADDR) begin
            hit_cpu = 1'b1;
        end else if (paddr == clock_supply_pkg::STATUS_ADDR) begin
            hit_status = 1'b1;
        end
        mapped = hit_master | hit_cpu | hit_status;
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign wr_master = psel & penable & pwrite & hit_master & pstrb[0];
    assign wr_cpu    = psel & penable & pwrite & hit_cpu & pstrb[0];

    // Status word is a read-only snapshot; writes to it are ignored
    assign status.slow_from_main  = master_ctl.slow_osc_disable;
    assign status.processor_clock = processor_clock_out_pin;
    assign status.battery_on      = supply_switches.battery_on;
    assign status.bus_on          = supply_switches.bus_on;

    // Register writes in the access cycle; read data prepared in the setup cycle
    always_comb begin
        next_master_ctl = master_ctl;
        next_cpu_div    = cpu_div;
        next_prdata     = prdata;
        if (wr_master) begin
            next_master_ctl = clock_supply_pkg::master_ctl_t'(pwdata[7:0]);
        end
        if (wr_cpu) begin
            // Upper two bits are dropped, so they never store
            next_cpu_div = pwdata[clock_supply_pkg::DIV_W-1:0];
        end
        if (psel && !penable && !pwrite) begin
            if (hit_master) begin
                next_prdata = {24'h000000, master_ctl};
            end else if (hit_cpu) begin
                next_prdata = {26'h0, cpu_div};
            end else if (hit_status) begin
                next_prdata = {28'h0000000, status};
            end else begin
                next_prdata = 32'h00000000;
            end
        end
    end

    // Registers; divisor reset gives about 3.69 MHz at 96 MHz master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_ctl <= clock_supply_pkg::MASTER_CTL_RESET;
            cpu_div    <= clock_supply_pkg::CPU_DIV_RESET;
            prdata     <= 32'h00000000;
        end else begin
            master_ctl <= next_master_ctl;
            cpu_div    <= next_cpu_div;
            prdata     <= next_prdata;
        end
    end

    // ************************************************************
    // Oscillator and PLL control
    // ************************************************************
    // Levels go straight from the register to the analog section
    assign fast_osc_enable = ~master_ctl.fast_osc_disable;
    assign vco_multiplier  = master_ctl.vco_multiplier;
    assign slow_osc_enable = ~master_ctl.slow_osc_disable;

    // ************************************************************
    // Processor clock divider
    // ************************************************************
    logic [clock_supply_pkg::DIV_W-1:0] half_cnt;
    logic [clock_supply_pkg::DIV_W-1:0] next_half_cnt;
    logic                               next_proc_clk;
    logic                               toggle_now;

    // Divisor 0 or 1 is not blocked; keeping clear of them is up to software
    // Toggle every divisor+1 cycles; >= lets a smaller divisor take hold
    always_comb begin
        next_half_cnt = half_cnt;
        next_proc_clk = processor_clock_out_pin;
        toggle_now    = 1'b0;
        if (!master_ctl.fast_osc_disable) begin
            if (half_cnt >= cpu_div) begin
                next_half_cnt = '0;
                next_proc_clk = ~processor_clock_out_pin;
                toggle_now    = 1'b1;
            end else begin
                next_half_cnt = half_cnt + 6'h01;
            end
        end
    end

    // Output pin from a flop, so it never glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt                <= '0;
            processor_clock_out_pin <= 1'b0;
        end else begin
            half_cnt                <= next_half_cnt;
            processor_clock_out_pin <= next_proc_clk;
        end
    end

    // ************************************************************
    // Peripheral gates and low-frequency clock
    // ************************************************************
    logic [11:0]                   slow_cnt;
    logic [11:0]                   next_slow_cnt;
    logic                          derived_slow;
    logic                          next_derived_slow;
    logic                          next_slow_clock;
    clock_supply_pkg::clock_gate_t next_gates;

    // Gates and slow clock choice; with the PLL stopped only the slow oscillator path runs
    always_comb begin
        next_slow_cnt     = slow_cnt;
        next_derived_slow = derived_slow;
        if (!master_ctl.fast_osc_disable) begin
            if (slow_cnt >= clock_supply_pkg::SLOW_HALF_LAST) begin
                next_slow_cnt     = 12'h000;
                next_derived_slow = ~derived_slow;
            end else begin
                next_slow_cnt = slow_cnt + 12'h001;
            end
        end
        // Slow oscillator pin is taken as synchronous; the mux is registered
        next_slow_clock = master_ctl.slow_osc_disable ? derived_slow
                                                      : slow_osc_clock;
        // A stopped PLL leaves nothing to gate, so every gate closes
        next_gates.keypad = ~(master_ctl.keypad_clock_disable
                              | master_ctl.fast_osc_disable);
        next_gates.card   = ~(master_ctl.card_clock_disable
                              | master_ctl.fast_osc_disable);
        next_gates.usb    = ~(master_ctl.usb_clock_disable
                              | master_ctl.fast_osc_disable);
    end

    // Registered gate levels for glitch-free clock gating cells
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt     <= 12'h000;
            derived_slow <= 1'b0;
            slow_clock   <= 1'b0;
            clock_gates  <= '0;
        end else begin
            slow_cnt     <= next_slow_cnt;
            derived_slow <= next_derived_slow;
            slow_clock   <= next_slow_clock;
            clock_gates  <= next_gates;
        end
    end

    // ************************************************************
    // Supply selection
    // ************************************************************
    supply_selector u_supply_selector (
        .pclk                   (pclk),
        .presetn                (presetn),
        .bus_supply_present     (bus_supply_present),
        .battery_supply_present (battery_supply_present),
        .supply_switches        (supply_switches)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    logic [clock_supply_pkg::DIV_W-1:0] since_toggle;
    logic                               steady;

    // Helper: cycles since last toggle, trusted only after a clean one
    // Long stops wrap the count; clearing steady keeps those periods unchecked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_toggle <= '0;
            steady       <= 1'b0;
        end else begin
            since_toggle <= toggle_now ? '0 : since_toggle + 6'h01;
            steady       <= (wr_cpu || master_ctl.fast_osc_disable) ? 1'b0 :
                            (toggle_now ? 1'b1 : steady);
        end
    end

    a_osc_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_master && pwdata[7]) |=> !fast_osc_enable ##1 $stable(processor_clock_out_pin))
        else $error("fast oscillator not stopped");
    a_keypad_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_master && pwdata[6]) |=> ##1 !clock_gates.keypad)
        else $error("keypad clock not gated");
    a_card_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_master && pwdata[5]) |=> ##1 !clock_gates.card)
        else $error("card clock not gated");
    a_usb_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_master && pwdata[4]) |=> ##1 !clock_gates.usb)
        else $error("usb clock not gated");
    a_slow_source: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (slow_clock == ($past(master_ctl.slow_osc_disable) ? $past(derived_slow)
                                                                  : $past(slow_osc_clock))))
        else $error("slow clock source wrong");
    a_slow_half: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_cnt == clock_supply_pkg::SLOW_HALF_LAST && !master_ctl.fast_osc_disable)
        |=> (derived_slow != $past(derived_slow)) ##1 $stable(derived_slow))
        else $error("derived slow clock half period wrong");
    a_vco_field: assert property (@(posedge pclk) disable iff (!presetn)
        wr_master |=> (vco_multiplier == $past(pwdata[2:0])))
        else $error("multiplier not taken from write");
    a_cpu_period: assert property (@(posedge pclk) disable iff (!presetn)
        (toggle_now && steady) |-> (since_toggle == cpu_div))
        else $error("processor clock half period wrong");
    a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_cpu)
        |=> (prdata[7:6] == 2'h0 && prdata[5:0] == cpu_div))
        else $error("divider read back wrong");
    a_div_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> (cpu_div == clock_supply_pkg::CPU_DIV_RESET))
        else $error("divider reset value wrong");
    // Stopped oscillator must freeze the processor clock and close the gates
    a_fast_gates: assert property (@(posedge pclk) disable iff (!presetn)
        master_ctl.fast_osc_disable |=> (clock_gates == '0))
        else $error("clock gates open with oscillator stopped");
    a_proc_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        master_ctl.fast_osc_disable |=> $stable(processor_clock_out_pin))
        else $error("processor clock ran with oscillator stopped");
    a_div_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cpu |=> (cpu_div == $past(pwdata[5:0])))
        else $error("divisor not taken from write");

    c_master_write: cover property (@(posedge pclk) disable iff (!presetn) wr_master);
    c_div_change: cover property (@(posedge pclk) disable iff (!presetn)
        wr_cpu ##[1:300] (toggle_now && steady));
    c_slow_main: cover property (@(posedge pclk) disable iff (!presetn)
        master_ctl.slow_osc_disable && $changed(slow_clock));
    c_fast_stop: cover property (@(posedge pclk) disable iff (!presetn) $fell(fast_osc_enable));

endmodule // clock_supply_control

// *** design/clock_supply_pkg.sv ***
// ****************************************************************
// Shared constants and types for clock and supply control
// ****************************************************************
package clock_supply_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    // Nominal low-frequency clock made from the main oscillator
    localparam int unsigned SLOW_HZ          = 32_768;
    localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / (2 * SLOW_HZ);
    localparam logic [11:0] SLOW_HALF_LAST   = 12'(SLOW_HALF_CYCLES - 1);
    // Dead time with both supply switches open, least time
    localparam int unsigned BREAK_NS     = 100;
    localparam int unsigned BREAK_CYCLES = (BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0]  BREAK_LAST   = 5'(BREAK_CYCLES - 1);
    localparam logic [4:0]  BREAK_MIN    = 5'(BREAK_CYCLES);

    // ************************************************************
    // Register map: printed offsets are indexes, byte address is 4x
    // ************************************************************
    localparam logic [15:0] MASTER_CTL_INDEX = 16'h008F;
    localparam logic [15:0] CPU_DIV_INDEX    = 16'hFFA1;
    localparam logic [15:0] STATUS_INDEX     = 16'hFFA2;
    localparam logic [31:0] MASTER_CTL_ADDR  = {14'h0000, MASTER_CTL_INDEX, 2'h0};
    localparam logic [31:0] CPU_DIV_ADDR     = {14'h0000, CPU_DIV_INDEX, 2'h0};
    localparam logic [31:0] STATUS_ADDR      = {14'h0000, STATUS_INDEX, 2'h0};

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    typedef struct packed {
        logic       fast_osc_disable;
        logic       keypad_clock_disable;
        logic       card_clock_disable;
        logic       usb_clock_disable;
        logic       slow_osc_disable;
        logic [2:0] vco_multiplier;
    } master_ctl_t;

    localparam master_ctl_t MASTER_CTL_RESET = 8'h0A;
    localparam int unsigned DIV_W            = 6;
    localparam logic [5:0]  CPU_DIV_RESET    = 6'h0C;

    typedef struct packed {
        logic keypad;
        logic card;
        logic usb;
    } clock_gate_t;

    typedef struct packed {
        logic bus_on;
        logic battery_on;
    } supply_switch_t;

    typedef struct packed {
        logic slow_from_main;
        logic processor_clock;
        logic battery_on;
        logic bus_on;
    } status_t;

    typedef enum logic [1:0] {
        SUP_OFF     = 2'b00,
        SUP_BUS     = 2'b01,
        SUP_BREAK   = 2'b10,
        SUP_BATTERY = 2'b11
    } supply_state_t;

endpackage

// *** design/supply_selector.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Break-before-make selection between bus and battery supply
// ****************************************************************
module supply_selector (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // Supply detection
    input  wire logic                        bus_supply_present,
    input  wire logic                        battery_supply_present,
    // Switch drive
    output clock_supply_pkg::supply_switch_t supply_switches
);

    clock_supply_pkg::supply_state_t state;
    clock_supply_pkg::supply_state_t next_state;
    logic [4:0]                      gap;
    logic [4:0]                      next_gap;
    clock_supply_pkg::supply_switch_t next_switches;

    // Source choice; bus always wins over battery
    always_comb begin
        next_state = state;
        next_gap   = gap;
        case (state)
            clock_supply_pkg::SUP_OFF: begin
                if (bus_supply_present) begin
                    next_state = clock_supply_pkg::SUP_BUS;
                end else if (battery_supply_present) begin
                    next_state = clock_supply_pkg::SUP_BATTERY;
                end
            end
            clock_supply_pkg::SUP_BUS: begin
                if (!bus_supply_present) begin
                    next_state = clock_supply_pkg::SUP_BREAK;
                    next_gap   = 5'h00;
                end
            end
            clock_supply_pkg::SUP_BATTERY: begin
                if (bus_supply_present || !battery_supply_present) begin
                    next_state = clock_supply_pkg::SUP_BREAK;
                    next_gap   = 5'h00;
                end
            end
            default: begin
                // Both open; wait out the dead time before closing one
                if (gap >= clock_supply_pkg::BREAK_LAST) begin
                    next_state = clock_supply_pkg::SUP_OFF;
                end else begin
                    next_gap = gap + 5'h01;
                end
            end
        endcase
        next_switches.bus_on     = (next_state == clock_supply_pkg::SUP_BUS);
        next_switches.battery_on = (next_state == clock_supply_pkg::SUP_BATTERY);
    end

    // Switch drive is registered so no decode glitch reaches the FETs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= clock_supply_pkg::SUP_OFF;
            gap             <= 5'h00;
            supply_switches <= '0;
        end else begin
            state           <= next_state;
            gap             <= next_gap;
            supply_switches <= next_switches;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    localparam int SETTLE_MAX = 26;
    logic [4:0] open_run;
    logic       ever_closed;

    // Helper: cycles with both switches open, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_run    <= 5'h00;
            ever_closed <= 1'b0;
        end else begin
            open_run    <= (supply_switches != '0) ? 5'h00 :
                           (open_run == 5'h1F) ? open_run : open_run + 5'h01;
            ever_closed <= ever_closed | (supply_switches != '0);
        end
    end

    a_never_both: assert property (@(posedge pclk) disable iff (!presetn)
        !(supply_switches.bus_on && supply_switches.battery_on))
        else $error("both supply switches closed");
    a_dead_time: assert property (@(posedge pclk) disable iff (!presetn)
        (ever_closed && ($rose(supply_switches.bus_on) || $rose(supply_switches.battery_on)))
        |-> $past(open_run) >= clock_supply_pkg::BREAK_MIN)
        else $error("supply switch closed before dead time");
    a_bus_priority: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bus_supply_present) |-> ##[1:SETTLE_MAX]
        (supply_switches.bus_on || !bus_supply_present))
        else $error("bus supply not selected in time");
    c_switchover: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(supply_switches.bus_on) ##[1:SETTLE_MAX] supply_switches.battery_on);

endmodule // supply_selector

// *** dv/clock_and_supply_select_test.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
// ****************************************
// Register-level bench for clock control
// ****************************************
module clock_and_supply_select_test;
    logic                             pclk, presetn, psel, penable, pwrite;
    logic [31:0]                      paddr, pwdata, prdata, rd;
    logic [3:0]                       pstrb;
    logic                             pready, pslverr, fast_osc_enable, slow_osc_enable;
    logic                             slow_osc_clock, slow_clock, processor_clock_out_pin;
    logic                             bus_supply_present, battery_supply_present, last_err;
    logic [2:0]                       vco_multiplier;
    clock_supply_pkg::clock_gate_t    clock_gates;
    clock_supply_pkg::supply_switch_t supply_switches;
    int                               errors, total_checks, n;
    realtime                          t0;

    clock_supply_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .fast_osc_enable, .vco_multiplier,
        .slow_osc_enable, .slow_osc_clock, .clock_gates, .slow_clock,
        .processor_clock_out_pin, .bus_supply_present, .battery_supply_present,
        .supply_switches);

    // Free-running 200 MHz clock
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end

    // One APB transfer; waits on pready rather than assuming zero wait
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic finish_test;
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #200_000;
        errors++;
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
        slow_osc_clock = 0; bus_supply_present = 1; battery_supply_present = 1; presetn = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, clock_supply_pkg::MASTER_CTL_ADDR, 0);
        `CHK("master", 32'h0000000A, rd)
        `CHK("mult", 3'h2, vco_multiplier)
        apb(0, clock_supply_pkg::CPU_DIV_ADDR, 0);
        `CHK("div_rst", 32'h0000000C, rd)
        apb(1, clock_supply_pkg::CPU_DIV_ADDR, 32'h000000FF);
        apb(0, clock_supply_pkg::CPU_DIV_ADDR, 0);
        `CHK("div_top", 32'h0000003F, rd)
        apb(0, 32'h00000010, 0);
        `CHK("unmapped", 1'b1, last_err)
        `CHK("unmapped_data", 32'h00000000, rd)
        // Each gate bit alone, slow oscillator enabled, multiplier kept legal
        for (int i = 0; i < 3; i++) begin
            apb(1, clock_supply_pkg::MASTER_CTL_ADDR, 32'h02 | (32'h40 >> i));
            repeat (2) @(posedge pclk);
            `CHK("gates", 3'b111 & ~(3'b100 >> i), clock_gates)
        end
        `CHK("slow_en", 1'b1, slow_osc_enable)
        slow_osc_clock <= 1;
        repeat (3) @(posedge pclk);
        `CHK("slow_pass", 1'b1, slow_clock)
        // Short divisor: period is twice (divisor plus one)
        apb(1, clock_supply_pkg::CPU_DIV_ADDR, 32'h00000002);
        repeat (2) @(posedge processor_clock_out_pin);
        t0 = $realtime;
        @(posedge processor_clock_out_pin);
        `CHK("cpu_period", 6, int'(($realtime - t0) / 5.0))
        apb(1, clock_supply_pkg::MASTER_CTL_ADDR, 32'h00000082);
        @(posedge pclk);
        `CHK("fast_off", 1'b0, fast_osc_enable)
        @(posedge pclk);
        `CHK("gates_off", 3'b000, clock_gates)
        // No slow crystal from here on, so software selects the derived clock
        slow_osc_clock <= 0;
        apb(1, clock_supply_pkg::MASTER_CTL_ADDR, 32'h0000000B);
        // First change may be the source switch, so time the third one
        for (int k = 0; k < 3; k++) begin
            rd[0] = slow_clock;
            n = 0;
            while (slow_clock === rd[0] && n < 4000) begin
                @(posedge pclk);
                n++;
            end
        end
        `CHK("slow_half", clock_supply_pkg::SLOW_HALF_CYCLES, n)
        `CHK("mult_new", 3'h3, vco_multiplier)
        `CHK("bus_first", 2'b10, supply_switches)
        // Bus removed: break before make onto battery
        bus_supply_present <= 0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            `CHK("overlap", 1'b0, supply_switches === 2'b11)
        end while (supply_switches !== 2'b01 && n < 60);
        `CHK("dead_time", 1'b1, n >= 21 && n <= 30)
        `CHK("battery", 2'b01, supply_switches)
        bus_supply_present <= 1;
        repeat (40) @(posedge pclk);
        `CHK("bus_back", 2'b10, supply_switches)
        finish_test();
    end
endmodule // clock_and_supply_select_test
